// ==== inc/src_defines.vh ====
// Register map, field positions, encodings and limits for the sequence run control.
// Included by the design file and the bench; definitions, no logic.
`ifndef SRC_DEFINES_VH
`define SRC_DEFINES_VH

// Register byte offsets
`define SRC_CTRL_OFF      12'h000
`define SRC_SRCSEL_OFF    12'h004
`define SRC_CMD_OFF       12'h008
`define SRC_WLOOP_OFF     12'h00c
`define SRC_SLOOP_OFF     12'h010
`define SRC_TBL_LEN_OFF   12'h014
`define SRC_JUMP_OFF      12'h018
`define SRC_STATUS_OFF    12'h01c
`define SRC_STEP_OFF      12'h020
`define SRC_WCNT_OFF      12'h024

// Control fields
`define SRC_CTRL_RUN_LSB  0
`define SRC_CTRL_ADV_LSB  2
`define SRC_CTRL_ARM_BIT  4
`define SRC_CTRL_FPAB_BIT 5
`define SRC_CTRL_RESET    32'h0000_0010

// Run modes
`define SRC_RUN_CONT      2'h0
`define SRC_RUN_TRIG      2'h1
`define SRC_RUN_GATE      2'h2

// Advance modes
`define SRC_ADV_AUTO      2'h0
`define SRC_ADV_ONCE      2'h1
`define SRC_ADV_STEP      2'h2

// Enable / initiate source codes
`define SRC_SRC_BUS       2'h0
`define SRC_SRC_EVENT     2'h1
`define SRC_SRC_TRIG      2'h2
`define SRC_SRC_FP        2'h3

// Command register bits (write one to act)
`define SRC_CMD_ENABLE    0
`define SRC_CMD_ABORT     1
`define SRC_CMD_INIT      2

// Loop count limits
`define SRC_LOOP_MIN      20'h00001
`define SRC_LOOP_MAX      20'hf4240
`define SRC_LOOP_W        20

// Sequence table
`define SRC_STEP_W        5
`define SRC_TBL_DEPTH     32

`endif

// ==== src/src_seq_run_ctrl.v ====
// Sequence run control: run mode, advance mode and arm option sequencer with APB registers.
// Assumes trigger, event, gate and button inputs are synchronous to pclk and already clean.
`default_nettype none
`include "src_defines.vh"

module src_seq_run_ctrl (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Outside control inputs
    input  wire        trig_in,
    input  wire        event_in,
    input  wire        gate_in,
    input  wire        fp_abort_btn,
    input  wire        fp_init_btn,
    // Waveform engine handshake
    input  wire        wave_done,
    // Sequencer outputs
    output reg         play,
    output reg         first_point_idle,
    output reg         first_wave_idle,
    output reg  [4:0]  step_index,
    output reg         step_restart,
    output reg         smart_trig_en,
    output reg         fp_lockout
);

    // States, one-hot
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_RUN  = 4'b0010;
    localparam [3:0] ST_DWELL = 4'b0100;
    localparam [3:0] ST_GATEW = 4'b1000;
    // ST_IDLE  : output idle, waiting for the start condition of the run mode
    // ST_RUN   : counting waveform repetitions of the current step
    // ST_DWELL : loops done, waveform keeps repeating until a jump arrives
    // ST_GATEW : started but the gate is low; the step position is kept
    // The state word is visible in the status register, so a host can see
    // a run that is stuck waiting for a gate or a jump without a probe.

    reg [31:0]                ctrl;
    reg [7:0]                 srcsel;
    reg [`SRC_LOOP_W-1:0]     wloop_cfg;
    reg [`SRC_LOOP_W-1:0]     sloop_cfg;
    reg [`SRC_STEP_W-1:0]     tbl_last;
    reg [`SRC_TBL_DEPTH-1:0]  jump_flags;
    reg [3:0]                 state;
    reg [`SRC_LOOP_W-1:0]     wcnt;
    reg [`SRC_LOOP_W-1:0]     scnt;
    reg                       event_q;
    reg                       jump_pend;
    reg [2:0]                 cmd_pulse;

    wire [1:0] run_mode = ctrl[`SRC_CTRL_RUN_LSB+1:`SRC_CTRL_RUN_LSB];
    wire [1:0] adv_mode = ctrl[`SRC_CTRL_ADV_LSB+1:`SRC_CTRL_ADV_LSB];
    wire       self_arm = ctrl[`SRC_CTRL_ARM_BIT];
    wire       fp_ab_en = ctrl[`SRC_CTRL_FPAB_BIT];
    wire [1:0] en_src   = srcsel[1:0];
    wire [1:0] init_src = srcsel[5:4];

    // Zero or over-range loop counts are clamped into the legal span.
    // Clamping at use rather than at write keeps the read-back equal to
    // what software wrote, at the cost of a comparator per use.
    // Counters start at one, so a count of one means a single pass.
    function [`SRC_LOOP_W-1:0] clamp_loop;
        input [`SRC_LOOP_W-1:0] v;
        begin
            if (v < `SRC_LOOP_MIN)
                clamp_loop = `SRC_LOOP_MIN;
            else if (v > `SRC_LOOP_MAX)
                clamp_loop = `SRC_LOOP_MAX;
            else
                clamp_loop = v;
        end
    endfunction

    // Picks the firing source for enable and initiate selections
    function src_fire;
        input [1:0] sel;
        input       bus;
        input       ev;
        input       tr;
        input       fp;
        begin
            case (sel)
                `SRC_SRC_BUS:   src_fire = bus;
                `SRC_SRC_EVENT: src_fire = ev;
                `SRC_SRC_TRIG:  src_fire = tr;
                `SRC_SRC_FP:    src_fire = fp;
                default:        src_fire = 1'b0;
            endcase
        end
    endfunction

    // APB: zero wait states, unmapped offsets answer with an error.
    // Every register is reachable in one access cycle, so pready is a
    // constant; a slower register file would need this tie replaced.
    // Writes to the read-only words are dropped without an error, since
    // the offsets are mapped; only offsets outside the map raise pslverr.
    wire apb_acc = psel & penable;
    wire apb_wr  = apb_acc & pwrite;
    reg  addr_ok;
    assign pready  = 1'b1;
    assign pslverr = apb_acc & ~addr_ok;

    always @* begin
        case (paddr)
            `SRC_CTRL_OFF, `SRC_SRCSEL_OFF, `SRC_CMD_OFF, `SRC_WLOOP_OFF,
            `SRC_SLOOP_OFF, `SRC_TBL_LEN_OFF, `SRC_JUMP_OFF, `SRC_STATUS_OFF,
            `SRC_STEP_OFF, `SRC_WCNT_OFF: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    wire event_edge = event_in & ~event_q;
    // Front-panel initiate is locked out while bus initiate is selected
    wire fp_ok      = (init_src != `SRC_SRC_BUS);
    wire bus_en     = cmd_pulse[`SRC_CMD_ENABLE];
    wire bus_abort  = cmd_pulse[`SRC_CMD_ABORT] & ~self_arm;
    wire fp_abort   = fp_abort_btn & fp_ab_en;
    wire abort      = bus_abort | fp_abort;
    wire enable_hit = ~self_arm &
                      src_fire(en_src, bus_en, event_edge, trig_in, 1'b0);
    wire init_hit   = (run_mode != `SRC_RUN_CONT) &
                      src_fire(init_src, cmd_pulse[`SRC_CMD_INIT], event_edge,
                               trig_in, fp_init_btn & fp_ok);
    // Continuous mode starts at once when self-armed, else on enable; the others on initiate
    wire start      = (run_mode == `SRC_RUN_CONT) ? (self_arm | enable_hit)
                                                  : init_hit;
    wire gate_ok    = (run_mode != `SRC_RUN_GATE) | gate_in;
    wire dwell_step = (adv_mode == `SRC_ADV_STEP) | jump_flags[step_index];
    wire last_step  = (step_index == tbl_last);
    wire wave_last  = (adv_mode == `SRC_ADV_STEP) | (wcnt >= clamp_loop(wloop_cfg));

    // Registers
    // Command bits are write-one pulses that live for exactly one cycle;
    // they never stay set, so a second write of the same command is needed
    // to act again and no command is replayed by a later unrelated write.
    // Mode changes take effect at once, also while a sequence is running;
    // software that needs a clean switch should abort first.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= `SRC_CTRL_RESET;
            srcsel     <= 8'h00;
            wloop_cfg  <= `SRC_LOOP_MIN;
            sloop_cfg  <= `SRC_LOOP_MIN;
            tbl_last   <= {`SRC_STEP_W{1'b0}};
            jump_flags <= {`SRC_TBL_DEPTH{1'b0}};
            cmd_pulse  <= 3'h0;
        end else begin
            cmd_pulse <= 3'h0;
            if (apb_wr) begin
                case (paddr)
                    `SRC_CTRL_OFF:    ctrl       <= pwdata & 32'h0000_003f;
                    `SRC_SRCSEL_OFF:  srcsel     <= pwdata[7:0];
                    `SRC_CMD_OFF:     cmd_pulse  <= pwdata[2:0];
                    `SRC_WLOOP_OFF:   wloop_cfg  <= pwdata[`SRC_LOOP_W-1:0];
                    `SRC_SLOOP_OFF:   sloop_cfg  <= pwdata[`SRC_LOOP_W-1:0];
                    `SRC_TBL_LEN_OFF: tbl_last   <= pwdata[`SRC_STEP_W-1:0];
                    `SRC_JUMP_OFF:    jump_flags <= pwdata;
                    default: ;
                endcase
            end
        end
    end

    // Read mux is combinational from paddr alone; the master takes the data
    // in the access cycle, while psel and penable still stand.
    // Command reads return zero because the read mux has no entry for that offset.
    always @* begin
        case (paddr)
            `SRC_CTRL_OFF:    prdata = ctrl;
            `SRC_SRCSEL_OFF:  prdata = {24'h0, srcsel};
            `SRC_WLOOP_OFF:   prdata = {12'h0, wloop_cfg};
            `SRC_SLOOP_OFF:   prdata = {12'h0, sloop_cfg};
            `SRC_TBL_LEN_OFF: prdata = {27'h0, tbl_last};
            `SRC_JUMP_OFF:    prdata = jump_flags;
            `SRC_STATUS_OFF:  prdata = {23'h0, jump_pend, smart_trig_en, fp_lockout,
                                        first_wave_idle, first_point_idle, state};
            `SRC_STEP_OFF:    prdata = {27'h0, step_index};
            `SRC_WCNT_OFF:    prdata = {12'h0, wcnt};
            default:          prdata = 32'h0;
        endcase
    end

    // Sequencer
    // Abort has priority over every state and clears position and counters.
    // A self-armed continuous run restarts right after an abort because its
    // start condition is always true; that matches the bus abort being
    // ignored there, and only the front-panel button can pause it briefly.
    // The event input serves enable, initiate and jump at the same time;
    // one edge may start a run and also be held as a pending jump.
    // Gate low pauses at the current step instead of rewinding, so a gate
    // burst resumes where the previous one stopped.
    // The waveform engine reports each finished repetition with wave_done;
    // all counting is done on that pulse, never on free-running cycles.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state        <= ST_IDLE;
            step_index   <= {`SRC_STEP_W{1'b0}};
            wcnt         <= `SRC_LOOP_MIN;
            scnt         <= `SRC_LOOP_MIN;
            event_q      <= 1'b0;
            jump_pend    <= 1'b0;
            play         <= 1'b0;
            step_restart <= 1'b0;
        end else begin
            event_q      <= event_in;
            step_restart <= 1'b0;
            // A jump event seen in the same cycle as its consumption is kept
            if (event_edge)
                jump_pend <= 1'b1;
            if (abort) begin
                state      <= ST_IDLE;
                step_index <= {`SRC_STEP_W{1'b0}};
                wcnt       <= `SRC_LOOP_MIN;
                scnt       <= `SRC_LOOP_MIN;
                jump_pend  <= 1'b0;
                play       <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (start) begin
                            state        <= gate_ok ? ST_RUN : ST_GATEW;
                            play         <= gate_ok;
                            step_restart <= 1'b1;
                            // An event edge in the start cycle is kept as a jump
                            jump_pend    <= event_edge;
                        end
                    end
                    ST_GATEW: begin
                        if (gate_in) begin
                            state <= ST_RUN;
                            play  <= 1'b1;
                        end
                    end
                    ST_RUN: begin
                        // Loop count first, then either dwell for a jump or
                        // move on; the last step wraps or ends the pass.
                        // In stepped advance the loop count is not used, so
                        // every repetition end leads straight to the dwell.
                        if (!gate_ok) begin
                            state <= ST_GATEW;
                            play  <= 1'b0;
                        end else if (wave_done) begin
                            if (!wave_last) begin
                                wcnt <= wcnt + 20'h1;
                            end else if (dwell_step) begin
                                state <= ST_DWELL;
                            end else begin
                                wcnt       <= `SRC_LOOP_MIN;
                                step_index <= last_step ? 5'h00 : step_index + 5'h01;
                                if (last_step && adv_mode == `SRC_ADV_ONCE) begin
                                    if (scnt >= clamp_loop(sloop_cfg)) begin
                                        state <= ST_IDLE;
                                        play  <= 1'b0;
                                        scnt  <= `SRC_LOOP_MIN;
                                    end else begin
                                        scnt <= scnt + 20'h1;
                                    end
                                end else if (last_step && run_mode == `SRC_RUN_TRIG &&
                                             adv_mode != `SRC_ADV_ONCE) begin
                                    // Triggered auto plays one pass per trigger
                                    state <= ST_IDLE;
                                    play  <= 1'b0;
                                end
                                // Auto in continuous/gated keeps looping
                            end
                        end
                    end
                    ST_DWELL: begin
                        // Waveform keeps repeating while waiting for the jump.
                        // The move happens on a repetition end so the output
                        // never cuts a waveform short; a jump seen in the
                        // same cycle is carried over as the next pending one.
                        if (!gate_ok) begin
                            state <= ST_GATEW;
                            play  <= 1'b0;
                        end else if (jump_pend && wave_done) begin
                            jump_pend  <= event_edge;
                            wcnt       <= `SRC_LOOP_MIN;
                            state      <= ST_RUN;
                            step_index <= last_step ? 5'h00 : step_index + 5'h01;
                            if (last_step && adv_mode == `SRC_ADV_ONCE) begin
                                if (scnt >= clamp_loop(sloop_cfg)) begin
                                    state <= ST_IDLE;
                                    play  <= 1'b0;
                                    scnt  <= `SRC_LOOP_MIN;
                                end else begin
                                    scnt <= scnt + 20'h1;
                                end
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

    // Idle kind and mode flags
    // The idle flags follow play with one cycle of lag; they are status for the
    // output stage, which must not rely on them in the first cycle of a run.
    // Smart trigger needs a triggered run without self-arm that is not single pass.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_point_idle <= 1'b0;
            first_wave_idle  <= 1'b0;
            smart_trig_en    <= 1'b0;
            fp_lockout       <= 1'b0;
        end else begin
            first_point_idle <= ~play & (run_mode != `SRC_RUN_CONT);
            first_wave_idle  <= ~play & (run_mode == `SRC_RUN_CONT);
            smart_trig_en    <= (run_mode == `SRC_RUN_TRIG) & ~self_arm &
                                (adv_mode != `SRC_ADV_ONCE);
            fp_lockout       <= ~fp_ok;
        end
    end


    // Limitations:
    // Trigger and button inputs are level sampled; a held trigger restarts
    // a triggered run every time it returns to idle.
    // Inputs must already be synchronous and free of bounce.
    // The table holds only jump flags and the last index; segment numbers
    // and per-step repeat counts are kept by the waveform engine side.
    // A shared wave loop count applies to every step.

endmodule // src_seq_run_ctrl
`default_nettype wire

// ==== testbench/src_far_model.sv ====
// Far side: trigger, event, gate and button sources and a waveform engine.
// Assumes the bench calls its tasks from its own thread on pclk edges.
`default_nettype none
module src_far_model #(
    parameter int WAVE_LEN = 4
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Watched output
    input  wire logic play,
    // Sources
    output var logic  trig_in,
    output var logic  event_in,
    output var logic  gate_in,
    output var logic  fp_abort_btn,
    output var logic  fp_init_btn,
    output var logic  wave_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    initial begin
        {trig_in, event_in, gate_in, fp_abort_btn, fp_init_btn} = 5'h00;
    end
    // One repetition ends every WAVE_LEN cycles while output plays
    always @(posedge pclk or negedge presetn) begin
        if (!presetn || !play) begin
            cnt <= 0;
            wave_done <= 1'b0;
        end else begin
            cnt <= (cnt == WAVE_LEN - 1) ? 0 : cnt + 1;
            wave_done <= (cnt == WAVE_LEN - 1);
        end
    end
    // One-cycle pulse: 0 trigger, 1 event edge, 3 initiate button, else abort button
    task automatic pulse(input int which);
        @(posedge pclk);
        case (which)
            0: trig_in <= 1'b1;
            1: event_in <= 1'b1;
            3: fp_init_btn <= 1'b1;
            default: fp_abort_btn <= 1'b1;
        endcase
        @(posedge pclk);
        {trig_in, event_in, fp_abort_btn, fp_init_btn} <= 4'h0;
    endtask
    task automatic set_gate(input logic v);
        @(posedge pclk);
        gate_in <= v;
    endtask
endmodule // src_far_model
`default_nettype wire

// ==== testbench/src_run_ctrl_props.sv ====
// Port checker for the sequence run control.
// Assumes one pclk domain and asynchronous active-low presetn.
`default_nettype none
module src_run_ctrl_props (
    // APB side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Sequencer side
    input wire logic        wave_done,
    input wire logic        play,
    input wire logic        first_point_idle,
    input wire logic        first_wave_idle,
    input wire logic [4:0]  step_index,
    input wire logic        step_restart,
    input wire logic        fp_lockout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic sel_wr;
    // Unaligned offsets are left alone: their decode is a designer choice
    assign acc = psel && penable && (paddr[1:0] == 2'h0);
    assign sel_wr = acc && pwrite && (paddr == 12'h004);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    zero_wait_a: assert property (psel && penable |-> pready) else $error("no ready");
    unmapped_err_a: assert property (acc && paddr > 12'h024 |-> pslverr) else $error("no error");
    mapped_ok_a: assert property (acc && paddr <= 12'h024 |-> !pslverr) else $error("bad error");
    bad_read_a: assert property (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    lockout_set_a: assert property (sel_wr && pwdata[5:4] == 2'h0 |-> ##[1:2] fp_lockout)
        else $error("lockout not set");
    lockout_clr_a: assert property (sel_wr && pwdata[5:4] != 2'h0 |-> ##[1:2] !fp_lockout)
        else $error("lockout not cleared");
    restart_first_a: assert property (step_restart |-> play && step_index == 5'h00)
        else $error("start not at first step");
    restart_pulse_a: assert property (step_restart |=> !step_restart) else $error("long restart");
    step_cause_a: assert property (play && $past(play) && !step_restart &&
        $changed(step_index) |-> $past(wave_done)) else $error("step moved without wave end");
    idle_excl_a: assert property (play && $past(play) |-> !first_point_idle && !first_wave_idle)
        else $error("idle shown while playing");
endmodule // src_run_ctrl_props
bind src_seq_run_ctrl src_run_ctrl_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wave_done(wave_done), .play(play),
    .first_point_idle(first_point_idle), .first_wave_idle(first_wave_idle),
    .step_index(step_index), .step_restart(step_restart), .fp_lockout(fp_lockout));
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench: APB tasks and run, advance and arm scenarios.
// Assumes the far-side model stands in for sources and the waveform engine.
`default_nettype none
`include "src_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        trig_in, event_in, gate_in, fp_abort_btn, fp_init_btn, wave_done;
    logic        play, first_point_idle, first_wave_idle, step_restart, smart_trig_en;
    logic        fp_lockout;
    logic [4:0]  step_index;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int          fail_count, cmp_count, done_count, cycles;
    src_seq_run_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trig_in(trig_in), .event_in(event_in), .gate_in(gate_in),
        .fp_abort_btn(fp_abort_btn), .fp_init_btn(fp_init_btn), .wave_done(wave_done),
        .play(play), .first_point_idle(first_point_idle), .first_wave_idle(first_wave_idle),
        .step_index(step_index), .step_restart(step_restart), .smart_trig_en(smart_trig_en),
        .fp_lockout(fp_lockout));
    src_far_model i_far (.pclk(pclk), .presetn(presetn), .play(play), .trig_in(trig_in),
        .event_in(event_in), .gate_in(gate_in), .fp_abort_btn(fp_abort_btn),
        .fp_init_btn(fp_init_btn), .wave_done(wave_done));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (wave_done && play) done_count++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run;
        end
    end
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bounded wait; the level is judged once the wait ends
    task automatic wait_play(input logic v);
        int n;
        n = 0;
        while (play !== v && n < 300) begin
            @(posedge pclk);
            n++;
        end
        check("play", play, v);
    endtask
    initial begin
        {psel, penable, pwrite, presetn, paddr, pwdata} = '0;
        {fail_count, cmp_count, done_count, cycles} = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `SRC_CTRL_OFF, 0);
        check("ctrl reset", rd, `SRC_CTRL_RESET);
        wait_play(1);
        apb(1, `SRC_CMD_OFF, 32'h2);
        repeat (3) @(posedge pclk);
        check("self armed abort", play, 1);
        apb(1, 12'h100, 32'h1);
        check("unmapped write", err, 1);
        apb(0, 12'h100, 0);
        check("unmapped read", {rd[30:0], err}, 1);
        apb(1, `SRC_SRCSEL_OFF, 32'h0);
        repeat (2) @(posedge pclk);
        check("lockout", fp_lockout, 1);
        apb(1, `SRC_SRCSEL_OFF, 32'h20);
        repeat (2) @(posedge pclk);
        check("lockout", fp_lockout, 0);
        apb(1, `SRC_WLOOP_OFF, 2);
        apb(1, `SRC_TBL_LEN_OFF, 1);
        apb(1, `SRC_JUMP_OFF, 0);
        apb(1, `SRC_CTRL_OFF, 32'h01);
        apb(1, `SRC_CMD_OFF, 32'h2);
        repeat (2) @(posedge pclk);
        check("smart", smart_trig_en, 1);
        apb(1, `SRC_CTRL_OFF, 32'h05);
        repeat (2) @(posedge pclk);
        check("idle", {smart_trig_en, play, first_point_idle, step_index}, 32'h20);
        for (int sl = 1; sl <= 2; sl++) begin
            apb(1, `SRC_SLOOP_OFF, sl);
            done_count = 0;
            i_far.pulse(0);
            wait_play(1);
            wait_play(0);
            check("repeats", done_count, 4 * sl);
        end
        apb(1, `SRC_SRCSEL_OFF, 32'h10);
        i_far.pulse(1);
        wait_play(1);
        wait_play(0);
        apb(1, `SRC_SRCSEL_OFF, 32'h21);
        apb(1, `SRC_CTRL_OFF, 32'h00);
        i_far.pulse(0);
        repeat (4) @(posedge pclk);
        check("cont idle", {play, first_wave_idle}, 1);
        i_far.pulse(1);
        wait_play(1);
        repeat (60) @(posedge pclk);
        check("auto", play, 1);
        apb(1, `SRC_CMD_OFF, 32'h2);
        repeat (2) @(posedge pclk);
        check("abort", {play, step_index}, 0);
        apb(1, `SRC_SRCSEL_OFF, 32'h20);
        apb(1, `SRC_CTRL_OFF, 32'h28);
        apb(1, `SRC_CMD_OFF, 32'h1);
        wait_play(1);
        repeat (20) @(posedge pclk);
        check("dwell", step_index, 0);
        i_far.pulse(1);
        repeat (8) @(posedge pclk);
        check("jump", step_index, 1);
        i_far.pulse(2);
        repeat (2) @(posedge pclk);
        check("fp abort", play, 0);
        apb(1, `SRC_CTRL_OFF, 32'h02);
        i_far.set_gate(1);
        i_far.pulse(0);
        wait_play(1);
        i_far.set_gate(0);
        repeat (3) @(posedge pclk);
        check("gate low", play, 0);
        apb(1, `SRC_CMD_OFF, 32'h2);
        apb(1, `SRC_SRCSEL_OFF, 32'h30);
        apb(1, `SRC_CTRL_OFF, 32'h05);
        repeat (2) @(posedge pclk);
        check("fp init lockout", fp_lockout, 0);
        i_far.pulse(3);
        wait_play(1);
        wait_play(0);
        complete_run;
    end
endmodule // tb
`default_nettype wire
